//--- core/cie_alu.sv
// Combinational arithmetic for the add and shift instructions.
// Assumes operands are already selected by the caller.
`timescale 1ns/10ps
`default_nettype none
module cie_alu
  import cie_pkg::*;
(
  input  wire logic [cie_pkg::DATA_W-1:0]  opA,
  input  wire logic [cie_pkg::DATA_W-1:0]  opB,
  input  wire logic                        carryIn,
  input  wire logic [cie_pkg::SHAMT_W-1:0] shiftAmt,
  output logic      [cie_pkg::DATA_W-1:0]  sum,
  output logic                             sumC,
  output logic                             sumDc,
  output logic                             sumOv,
  output logic      [cie_pkg::DATA_W-1:0]  asr1,
  output logic                             asr1C,
  output logic      [cie_pkg::DATA_W-1:0]  asrN
);
  logic [DATA_W:0]  wide;
  logic [NIB_W:0]   nib;

  always_comb begin
    wide  = {1'b0, opA} + {1'b0, opB} + {{DATA_W{1'b0}}, carryIn};
    nib   = {1'b0, opA[NIB_W-1:0]} + {1'b0, opB[NIB_W-1:0]}
            + {{NIB_W{1'b0}}, carryIn};
    sum   = wide[DATA_W-1:0];
    sumC  = wide[DATA_W];
    sumDc = nib[NIB_W];
    sumOv = (opA[SIGN_BIT] == opB[SIGN_BIT]) &&
            (sum[SIGN_BIT] != opA[SIGN_BIT]);
    // Sign bit is kept while shifting right
    asr1  = {opA[SIGN_BIT], opA[DATA_W-1:1]};
    asr1C = opA[0];
    asrN  = DATA_W'($signed(opA) >>> shiftAmt);
  end
endmodule : cie_alu
`default_nettype wire

//--- core/cie_branch_eval.sv
// Evaluates branch conditions against the status flags.
// Assumes flags come from the executing core on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cie_branch_eval
  import cie_pkg::*;
(
  input  wire logic [cie_pkg::FL_W-1:0] flags,
  input  wire cie_pkg::cie_cc_e         cond,
  output logic                          taken
);
  logic c, z, ov, n;

  always_comb begin
    c  = flags[FL_C];
    z  = flags[FL_Z];
    ov = flags[FL_OV];
    n  = flags[FL_N];
    unique case (cond)
      CIE_CC_C:   taken = c;
      CIE_CC_GE:  taken = ~(n ^ ov);
      CIE_CC_GEU: taken = c;
      CIE_CC_GT:  taken = ~z & ~(n ^ ov);
      CIE_CC_GTU: taken = c & ~z;
      CIE_CC_LE:  taken = z | (n ^ ov);
      CIE_CC_LEU: taken = ~c | z;
      CIE_CC_LT:  taken = n ^ ov;
      CIE_CC_LTU: taken = ~c;
      CIE_CC_N:   taken = n;
      CIE_CC_NC:  taken = ~c;
      CIE_CC_NN:  taken = ~n;
      CIE_CC_NOV: taken = ~ov;
      CIE_CC_NZ:  taken = ~z;
      CIE_CC_OV:  taken = ov;
      CIE_CC_Z:   taken = z;
    endcase
  end
endmodule : cie_branch_eval
`default_nettype wire

//--- core/cie_exec.sv
// Execution unit for a subset of a 16-bit processor's instructions.
// Assumes a decoder presents one instruction with operands already read;
// the unit answers with results, flags, and a busy level while stalling.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Add-with-carry sums both operands plus carry, in all five operand forms.
// - Every add form is one word, one cycle, updating C, DC, N, OV, Z.
// - Single-step arithmetic right shift keeps sign, one cycle, sets C,N,OV,Z.
// - Multi-step shift by register or 5-bit literal, one cycle, sets N,Z.
// - Conditional branch 1 or 2 cycles; unconditional and computed take 2.
// - Bit test skip if clear uses 4-bit index, 1, 2 or 3 cycles, no flags.
// - Table read low loads program bits 15:0 to destination, 2 cycles.
// - Table write high puts source bits 7:0 into program bits 23:16, 2 cycles.
// - Table write low puts full source into program bits 15:0, 2 cycles.
// - Zero extend fills upper byte with zeros, one cycle, sets C, Z, N.
module cie_exec
  import cie_pkg::*;
(
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire logic                           instValid,
  input  wire cie_pkg::cie_op_e               op,
  input  wire cie_pkg::cie_form_e             form,
  input  wire cie_pkg::cie_cc_e               cond,
  input  wire logic [cie_pkg::DATA_W-1:0]     fileValue,
  input  wire logic [cie_pkg::DATA_W-1:0]     default_working_accumulator,
  input  wire logic [cie_pkg::DATA_W-1:0]     base_register,
  input  wire logic [cie_pkg::DATA_W-1:0]     source_register,
  input  wire logic [cie_pkg::DATA_W-1:0]     destination_register,
  input  wire logic [cie_pkg::TEN_BIT_LITERAL_W-1:0]    ten_bit_literal,
  input  wire logic [cie_pkg::FIVE_BIT_LITERAL_W-1:0]     five_bit_literal,
  input  wire logic                           shiftByLiteral,
  input  wire logic [cie_pkg::BIT_INDEX_FIELD_W-1:0]     bit_index_field,
  input  wire logic                           nextIsTwoWord,
  input  wire logic [cie_pkg::PADDR_W-1:0]    branchTarget,
  input  wire logic [cie_pkg::PROG_W-1:0]     progRdData,
  output logic                                busy,
  output logic [cie_pkg::DATA_W-1:0]          result_r,
  output logic                                resultValid_r,
  output logic [cie_pkg::FL_W-1:0]            flags_r,
  output logic                                pcLoad_r,
  output logic [cie_pkg::PADDR_W-1:0]         pcTarget_r,
  output logic                                skipNext_r,
  output logic                                progRdEn_r,
  output logic                                progWrEn_r,
  output logic [cie_pkg::PROG_W-1:0]          progWrData_r,
  output logic [cie_pkg::PROG_W-1:0]          progWrMask_r,
  output logic [cie_pkg::PADDR_W-1:0]         progAddr_r
);

  // ****************************************************************
  // Arithmetic and condition helpers
  // ****************************************************************
  logic [DATA_W-1:0]  opA, opB;
  logic               carryIn;
  logic [SHAMT_W-1:0] shiftAmt;
  logic [DATA_W-1:0]  sum, asr1, asrN;
  logic               sumC, sumDc, sumOv, asr1C, condTaken;

  function automatic logic isZero(input logic [DATA_W-1:0] v);
    isZero = (v == '0);
  endfunction : isZero

  always_comb begin
    opA      = fileValue;
    opB      = default_working_accumulator;
    unique case (form)
      CIE_FORM_F, CIE_FORM_F_ACC: begin
        opA = fileValue;
        opB = default_working_accumulator;
      end
      CIE_FORM_TEN_BIT_LITERAL: begin
        opA = DATA_W'(ten_bit_literal);
        opB = destination_register;
      end
      CIE_FORM_REG_REG: begin
        opA = base_register;
        opB = source_register;
      end
      CIE_FORM_REG_FIVE_BIT_LITERAL: begin
        opA = base_register;
        opB = DATA_W'(five_bit_literal);
      end
    endcase
    if (op == CIE_OP_ASR1) begin
      opA = source_register;
    end else if (op == CIE_OP_ASRN) begin
      opA = base_register;
    end
    // Carry joins the sum only for the carry form
    carryIn = (op == CIE_OP_ADD_WITH_CARRY_OP) ? flags_r[FL_C] : 1'b0;
    // Shift counts beyond the word width clip to the low four bits
    shiftAmt = shiftByLiteral ? five_bit_literal[SHAMT_W-1:0]
                              : source_register[SHAMT_W-1:0];
  end

  cie_alu uAlu (
    .opA      (opA),
    .opB      (opB),
    .carryIn  (carryIn),
    .shiftAmt (shiftAmt),
    .sum      (sum),
    .sumC     (sumC),
    .sumDc    (sumDc),
    .sumOv    (sumOv),
    .asr1     (asr1),
    .asr1C    (asr1C),
    .asrN     (asrN)
  );

  cie_branch_eval uBr (
    .flags (flags_r),
    .cond  (cond),
    .taken (condTaken)
  );

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    CIE_ST_IDLE,
    CIE_ST_STALL
  } cie_state_e;

  cie_state_e  state_r, state_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic [1:0]  cycles;
  logic        bitClear;

  always_comb begin
    bitClear = ~source_register[bit_index_field];
    cycles   = CYC_ONE;
    unique case (op)
      CIE_OP_BRA_COND:   cycles = condTaken ? CYC_TWO : CYC_ONE;
      CIE_OP_BRA_UNCOND,
      CIE_OP_BRA_COMP:   cycles = CYC_TWO;
      CIE_OP_BIT_TEST_SKIP_CLEAR_OP:       cycles = !bitClear ? CYC_ONE :
                                  (nextIsTwoWord ? CYC_THREE : CYC_TWO);
      CIE_OP_TBLRD_LOW,
      CIE_OP_TBLWR_HIGH,
      CIE_OP_TBLWR_LOW:  cycles = CYC_TWO;
      default:           cycles = CYC_ONE;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      CIE_ST_IDLE: begin
        if (instValid && cycles != CYC_ONE) begin
          state_nxt = CIE_ST_STALL;
          cnt_nxt   = cycles - CYC_ONE;
        end
      end
      CIE_ST_STALL: begin
        cnt_nxt = cnt_r - CYC_ONE;
        if (cnt_r == CYC_ONE) begin
          state_nxt = CIE_ST_IDLE;
        end
      end
      default: state_nxt = CIE_ST_IDLE;
    endcase
  end

  // Decoder must hold the instruction while busy is high
  assign busy = (state_r == CIE_ST_STALL);

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= CIE_ST_IDLE;
      cnt_r   <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ****************************************************************
  // Results, flags and program memory access
  // ****************************************************************
  logic [DATA_W-1:0] result_nxt;
  logic              resultValid_nxt, pcLoad_nxt, skipNext_nxt;
  logic              progRdEn_nxt, progWrEn_nxt;
  logic [FL_W-1:0]   flags_nxt;
  logic [PADDR_W-1:0] pcTarget_nxt, progAddr_nxt;
  logic [PROG_W-1:0] progWrData_nxt, progWrMask_nxt;
  logic              start, finish;

  always_comb begin
    start           = instValid && (state_r == CIE_ST_IDLE);
    finish          = busy && (cnt_r == CYC_ONE);
    result_nxt      = result_r;
    resultValid_nxt = 1'b0;
    flags_nxt       = flags_r;
    pcLoad_nxt      = 1'b0;
    pcTarget_nxt    = pcTarget_r;
    skipNext_nxt    = 1'b0;
    progRdEn_nxt    = 1'b0;
    progWrEn_nxt    = 1'b0;
    progWrData_nxt  = progWrData_r;
    progWrMask_nxt  = progWrMask_r;
    progAddr_nxt    = progAddr_r;
    if (start) begin
      unique case (op)
        CIE_OP_ADD, CIE_OP_ADD_WITH_CARRY_OP: begin
          result_nxt      = sum;
          resultValid_nxt = 1'b1;
          flags_nxt[FL_C]  = sumC;
          flags_nxt[FL_DC] = sumDc;
          flags_nxt[FL_OV] = sumOv;
          flags_nxt[FL_N]  = sum[SIGN_BIT];
          flags_nxt[FL_Z]  = isZero(sum);
        end
        CIE_OP_ASR1: begin
          result_nxt      = asr1;
          resultValid_nxt = 1'b1;
          flags_nxt[FL_C]  = asr1C;
          flags_nxt[FL_OV] = 1'b0;
          flags_nxt[FL_N]  = asr1[SIGN_BIT];
          flags_nxt[FL_Z]  = isZero(asr1);
        end
        CIE_OP_ASRN: begin
          result_nxt      = asrN;
          resultValid_nxt = 1'b1;
          flags_nxt[FL_N]  = asrN[SIGN_BIT];
          flags_nxt[FL_Z]  = isZero(asrN);
        end
        CIE_OP_BRA_COND: begin
          pcLoad_nxt   = condTaken;
          pcTarget_nxt = branchTarget;
        end
        CIE_OP_BRA_UNCOND, CIE_OP_BRA_COMP: begin
          pcLoad_nxt   = 1'b1;
          pcTarget_nxt = branchTarget;
        end
        CIE_OP_BIT_TEST_SKIP_CLEAR_OP: skipNext_nxt = bitClear;
        CIE_OP_TBLRD_LOW: begin
          progRdEn_nxt = 1'b1;
          progAddr_nxt = source_register;
        end
        CIE_OP_TBLWR_HIGH: begin
          progWrEn_nxt   = 1'b1;
          progAddr_nxt   = destination_register;
          progWrData_nxt = {source_register[BYTE_W-1:0],
                            {HIGH_LSB{1'b0}}};
          progWrMask_nxt = {{BYTE_W{1'b1}}, {HIGH_LSB{1'b0}}};
        end
        CIE_OP_TBLWR_LOW: begin
          progWrEn_nxt   = 1'b1;
          progAddr_nxt   = destination_register;
          progWrData_nxt = {{BYTE_W{1'b0}}, source_register};
          progWrMask_nxt = {{BYTE_W{1'b0}}, {HIGH_LSB{1'b1}}};
        end
        CIE_OP_ZEXT: begin
          result_nxt      = {{BYTE_W{1'b0}}, source_register[BYTE_W-1:0]};
          resultValid_nxt = 1'b1;
          flags_nxt[FL_C] = 1'b1;
          flags_nxt[FL_N] = 1'b0;
          flags_nxt[FL_Z] = (source_register[BYTE_W-1:0] == '0);
        end
        default: ;
      endcase
    end
    // Read data arrives one cycle after the request
    if (finish && op == CIE_OP_TBLRD_LOW) begin
      result_nxt      = progRdData[LOW_MSB:0];
      resultValid_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_r      <= 16'h0000;
      resultValid_r <= 1'b0;
      flags_r       <= FLAGS_RST;
      pcLoad_r      <= 1'b0;
      pcTarget_r    <= 16'h0000;
      skipNext_r    <= 1'b0;
      progRdEn_r    <= 1'b0;
      progWrEn_r    <= 1'b0;
      progWrData_r  <= 24'h00_0000;
      progWrMask_r  <= 24'h00_0000;
      progAddr_r    <= 16'h0000;
    end else begin
      result_r      <= result_nxt;
      resultValid_r <= resultValid_nxt;
      flags_r       <= flags_nxt;
      pcLoad_r      <= pcLoad_nxt;
      pcTarget_r    <= pcTarget_nxt;
      skipNext_r    <= skipNext_nxt;
      progRdEn_r    <= progRdEn_nxt;
      progWrEn_r    <= progWrEn_nxt;
      progWrData_r  <= progWrData_nxt;
      progWrMask_r  <= progWrMask_nxt;
      progAddr_r    <= progAddr_nxt;
    end
  end

endmodule : cie_exec
`default_nettype wire

//--- core/cie_pkg.sv
// Constants and types for the instruction subset execution block.
// Assumes a 16-bit data path and a 24-bit program word.
package cie_pkg;

  localparam int unsigned DATA_W     = 16;
  localparam int unsigned PROG_W     = 24;
  localparam int unsigned PADDR_W    = 16;
  localparam int unsigned TEN_BIT_LITERAL_W    = 10;
  localparam int unsigned FIVE_BIT_LITERAL_W     = 5;
  localparam int unsigned BIT_INDEX_FIELD_W     = 4;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned SHAMT_W    = 4;
  localparam int unsigned HIGH_LSB   = 16;
  localparam int unsigned LOW_MSB    = 15;
  localparam int unsigned SIGN_BIT   = 15;

  // Cycle counts per instruction kind
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // Status flag vector positions
  localparam int unsigned FL_C  = 0;
  localparam int unsigned FL_Z  = 1;
  localparam int unsigned FL_OV = 2;
  localparam int unsigned FL_N  = 3;
  localparam int unsigned FL_DC = 4;
  localparam int unsigned FL_W  = 5;
  localparam logic [FL_W-1:0] FLAGS_RST = 5'h00;

  typedef enum logic [3:0] {
    CIE_OP_NOP,
    CIE_OP_ADD,
    CIE_OP_ADD_WITH_CARRY_OP,
    CIE_OP_ASR1,
    CIE_OP_ASRN,
    CIE_OP_BRA_COND,
    CIE_OP_BRA_UNCOND,
    CIE_OP_BRA_COMP,
    CIE_OP_BIT_TEST_SKIP_CLEAR_OP,
    CIE_OP_TBLRD_LOW,
    CIE_OP_TBLWR_HIGH,
    CIE_OP_TBLWR_LOW,
    CIE_OP_ZEXT
  } cie_op_e;

  // Operand forms of the add family
  typedef enum logic [2:0] {
    CIE_FORM_F,
    CIE_FORM_F_ACC,
    CIE_FORM_TEN_BIT_LITERAL,
    CIE_FORM_REG_REG,
    CIE_FORM_REG_FIVE_BIT_LITERAL
  } cie_form_e;

  typedef enum logic [3:0] {
    CIE_CC_C,
    CIE_CC_GE,
    CIE_CC_GEU,
    CIE_CC_GT,
    CIE_CC_GTU,
    CIE_CC_LE,
    CIE_CC_LEU,
    CIE_CC_LT,
    CIE_CC_LTU,
    CIE_CC_N,
    CIE_CC_NC,
    CIE_CC_NN,
    CIE_CC_NOV,
    CIE_CC_NZ,
    CIE_CC_OV,
    CIE_CC_Z
  } cie_cc_e;

endpackage : cie_pkg

//--- dv/cie_exec_sva.sv
// Checker for port timing and results of the execution unit.
// Assumes it is bound into cie_exec and shares its clock and reset.
`timescale 1ns/10ps
`default_nettype none
module cie_exec_sva
  import cie_pkg::*;
(
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         instValid,
  input wire cie_pkg::cie_op_e             op,
  input wire logic [cie_pkg::DATA_W-1:0]   source_register,
  input wire logic [cie_pkg::BIT_INDEX_FIELD_W-1:0]   bit_index_field,
  input wire logic                         nextIsTwoWord,
  input wire logic [cie_pkg::PADDR_W-1:0]  branchTarget,
  input wire logic                         busy,
  input wire logic [cie_pkg::DATA_W-1:0]   result_r,
  input wire logic                         resultValid_r,
  input wire logic [cie_pkg::FL_W-1:0]     flags_r,
  input wire logic                         pcLoad_r,
  input wire logic [cie_pkg::PADDR_W-1:0]  pcTarget_r,
  input wire logic                         skipNext_r,
  input wire logic                         progRdEn_r,
  input wire logic                         progWrEn_r,
  input wire logic [cie_pkg::PROG_W-1:0]   progWrData_r,
  input wire logic [cie_pkg::PROG_W-1:0]   progWrMask_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic       take;
  logic       noFlag;
  logic [7:0] srcB;
  logic [2:0] keep3;
  // A request held while busy is the same one, so it is no new take
  assign take   = instValid && !busy;
  assign srcB   = source_register[7:0];
  assign keep3  = {flags_r[FL_DC], flags_r[FL_OV], flags_r[FL_C]};
  assign noFlag = op inside {CIE_OP_BRA_COND, CIE_OP_BRA_UNCOND,
    CIE_OP_BRA_COMP, CIE_OP_BIT_TEST_SKIP_CLEAR_OP, CIE_OP_TBLRD_LOW, CIE_OP_TBLWR_HIGH,
    CIE_OP_TBLWR_LOW};
  // ****************************************************************
  // Properties
  // ****************************************************************
  add_one_cyc_a: assert property (take && op inside {CIE_OP_ADD,
    CIE_OP_ADD_WITH_CARRY_OP} |=> resultValid_r && !busy)
    else $error("add not finished in one cycle");
  asr_one_a: assert property (take && op == CIE_OP_ASR1 |=>
    !busy && !flags_r[FL_OV] && flags_r[FL_N] == result_r[SIGN_BIT])
    else $error("single shift flags wrong");
  asrn_keep_a: assert property (take && op == CIE_OP_ASRN
    |=> $stable(keep3) && !busy) else $error("multi shift touched flags");
  bra_two_a: assert property (take && op inside {CIE_OP_BRA_UNCOND,
    CIE_OP_BRA_COMP} |=> busy && pcLoad_r ##1 !busy)
    else $error("branch not two cycles");
  bra_tgt_a: assert property (take && op == CIE_OP_BRA_UNCOND
    |=> pcTarget_r == $past(branchTarget)) else $error("bad target");
  skip_clr_a: assert property (take && op == CIE_OP_BIT_TEST_SKIP_CLEAR_OP &&
    !source_register[bit_index_field] |=> skipNext_r && busy)
    else $error("clear bit did not skip");
  no_flag_a: assert property (take && noFlag
    |=> $stable(flags_r)) else $error("flags changed");
  tbl_two_a: assert property (take && op inside {CIE_OP_TBLRD_LOW,
    CIE_OP_TBLWR_HIGH, CIE_OP_TBLWR_LOW} |=> busy ##1 !busy)
    else $error("table op not two cycles");
  rd_seq_a: assert property (take && op == CIE_OP_TBLRD_LOW
    |=> progRdEn_r ##1 resultValid_r) else $error("read sequence wrong");
  wr_high_a: assert property (take && op == CIE_OP_TBLWR_HIGH |=>
    progWrEn_r && progWrMask_r == 24'hFF_0000 &&
    progWrData_r[23:16] == $past(srcB)) else $error("high write wrong");
  wr_low_a: assert property (take && op == CIE_OP_TBLWR_LOW |=>
    progWrEn_r && progWrMask_r == 24'h00_FFFF &&
    progWrData_r[15:0] == $past(source_register))
    else $error("low write wrong");
  zext_fill_a: assert property (take && op == CIE_OP_ZEXT |=>
    result_r == {8'h00, $past(srcB)} && flags_r[FL_C] && !flags_r[FL_N])
    else $error("zero extend wrong");
  cover property (take && op == CIE_OP_BIT_TEST_SKIP_CLEAR_OP && nextIsTwoWord);
  cover property (pcLoad_r);
  cover property (progWrEn_r);
  cover property (progRdEn_r ##1 resultValid_r);
endmodule : cie_exec_sva
`default_nettype wire

//--- dv/cie_prog_mem_model.sv
// Program memory model answering the unit's table reads and writes.
// Assumes 16 words, addressed by the low four address bits.
`timescale 1ns/10ps
`default_nettype none
module cie_prog_mem_model
  import cie_pkg::*;
(
  input wire logic                         mclk,
  input wire logic                         progRdEn_r,
  input wire logic                         progWrEn_r,
  input wire logic [cie_pkg::PADDR_W-1:0]  progAddr_r,
  input wire logic [cie_pkg::PROG_W-1:0]   progWrData_r,
  input wire logic [cie_pkg::PROG_W-1:0]   progWrMask_r,
  output logic     [cie_pkg::PROG_W-1:0]   progRdData
);
  logic [PROG_W-1:0] mem [16];
  logic [PROG_W-1:0] junk_r = 24'hA5_5AA5;
  logic              hold_r = 1'b0;
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = {8'h3C, 8'h5A ^ 8'(i), 8'hC3};
    end
  end
  // Only masked bits change, so a byte write keeps the other lanes
  always @(posedge mclk) begin
    hold_r <= progRdEn_r;
    junk_r <= ~junk_r;
    if (progWrEn_r) begin
      mem[progAddr_r[3:0]] <= (mem[progAddr_r[3:0]] & ~progWrMask_r) |
                              (progWrData_r & progWrMask_r);
    end
  end
  // Outside a read and the cycle after it the bus shows a changing pattern, never stale data
  assign progRdData = (progRdEn_r || hold_r) ? mem[progAddr_r[3:0]] : junk_r;
endmodule : cie_prog_mem_model
`default_nettype wire

//--- dv/cpu_instruction_subset_exec_tb.sv
// Self-checking bench for the execution unit with a program memory model.
// Assumes one 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module cpu_instruction_subset_exec_tb
  import cie_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic instValid = 1'b0;
  logic byLit = 1'b0;
  logic twoWord = 1'b0;
  cie_op_e op = CIE_OP_NOP;
  cie_form_e form = CIE_FORM_F;
  cie_cc_e cond = CIE_CC_C;
  logic [DATA_W-1:0] fileValue = '0, acc = '0, baseR = '0;
  logic [DATA_W-1:0] srcR = '0, dstR = '0, result_r;
  logic [TEN_BIT_LITERAL_W-1:0] litTen = '0;
  logic [FIVE_BIT_LITERAL_W-1:0] litFive = '0;
  logic [BIT_INDEX_FIELD_W-1:0] bitSel = '0;
  logic [PADDR_W-1:0] target = '0, pcTarget_r, progAddr_r;
  logic [PROG_W-1:0] rdData, progWrData_r, progWrMask_r, wD, wM;
  logic busy, resultValid_r, pcLoad_r, skipNext_r, progRdEn_r, progWrEn_r;
  logic pcL, skp, rdE, wrE, rV;
  logic [1:0] cyc;
  logic [FL_W-1:0] flags_r, eF;
  logic [DATA_W-1:0] res;
  int miscompares = 0;
  int n_tests = 0;
  always #25 mclk = ~mclk;
  cie_exec uut (.mclk, .rst, .instValid, .op, .form, .cond, .fileValue,
    .default_working_accumulator(acc), .base_register(baseR),
    .source_register(srcR), .destination_register(dstR),
    .ten_bit_literal(litTen), .five_bit_literal(litFive),
    .shiftByLiteral(byLit), .bit_index_field(bitSel),
    .nextIsTwoWord(twoWord), .branchTarget(target), .progRdData(rdData),
    .busy, .result_r, .resultValid_r, .flags_r, .pcLoad_r, .pcTarget_r,
    .skipNext_r, .progRdEn_r, .progWrEn_r, .progWrData_r, .progWrMask_r,
    .progAddr_r);
  cie_prog_mem_model mem (.mclk, .progRdEn_r, .progWrEn_r, .progAddr_r,
    .progWrData_r, .progWrMask_r, .progRdData(rdData));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic chkD(input logic [PROG_W-1:0] g, input logic [PROG_W-1:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chkD
  task automatic chkF(input logic [FL_W-1:0] g, input logic [FL_W-1:0] e);
    chkD(24'(g), 24'(e));
  endtask : chkF
  task automatic chkC(input logic [1:0] g, input logic [1:0] e);
    chkD(24'(g), 24'(e));
  endtask : chkC
  // Pulses are taken one cycle after the take, results once busy falls
  task automatic exec(input cie_op_e o);
    @(negedge mclk);
    op = o;
    instValid = 1'b1;
    @(negedge mclk);
    {pcL, skp, rdE, wrE, wD, wM} = {pcLoad_r, skipNext_r, progRdEn_r,
      progWrEn_r, progWrData_r, progWrMask_r};
    cyc = 2'h1;
    for (int k = 0; k < 3 && busy === 1'b1; k++) begin
      cyc = cyc + 2'h1;
      @(negedge mclk);
    end
    if (busy !== 1'b0) begin
      miscompares++;
      print_verdict();
    end
    {rV, res} = {resultValid_r, result_r};
    instValid = 1'b0;
  endtask : exec
  function automatic logic [20:0] addX(input logic [15:0] a, b, input logic c);
    logic [16:0] s;
    logic [4:0] d;
    s = {1'b0, a} + {1'b0, b} + 17'(c);
    d = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(c);
    return {d[4], s[15], a[15] == b[15] && s[15] != a[15],
      s[15:0] == 16'h0000, s[16], s[15:0]};
  endfunction : addX
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Mask bit i: condition i is taken under the flags held on entry
  task automatic t_branch(input logic [15:0] m, input logic [FL_W-1:0] fE);
    target = 16'h0ABC;
    srcR = 16'h0ABC;
    for (int i = 0; i < 16; i++) begin
      cond = cie_cc_e'(i);
      exec(CIE_OP_BRA_COND);
      chkC(cyc, m[i] ? 2'h2 : 2'h1);
      chkD(24'(pcL), 24'(m[i]));
      chkF(flags_r, fE);
    end
    exec(CIE_OP_BRA_UNCOND);
    chkC(cyc, 2'h2);
    chkD(24'(pcTarget_r), 24'h00_0ABC);
    exec(CIE_OP_BRA_COMP);
    chkC(cyc, 2'h2);
    $display("branch test done");
  endtask : t_branch
  task automatic t_add();
    logic [20:0] x;
    {fileValue, acc, dstR, litTen} = {16'h7FF0, 16'h000F, 16'h1234, 10'h3FF};
    {baseR, srcR, litFive} = {16'hFFFF, 16'h0001, 5'h1F};
    form = CIE_FORM_REG_REG;
    exec(CIE_OP_ADD);
    x = addX(baseR, srcR, 1'b0);
    chkD(24'(res), 24'(x[15:0]));
    chkF(flags_r, x[20:16]);
    {baseR, srcR} = {16'h8000, 16'h8000};
    for (int f = 0; f < 5; f++) begin
      form = cie_form_e'(f);
      case (f)
        0, 1: x = addX(fileValue, acc, x[16]);
        2: x = addX({6'h00, litTen}, dstR, x[16]);
        3: x = addX(baseR, srcR, x[16]);
        default: x = addX(baseR, {11'h000, litFive}, x[16]);
      endcase
      exec(CIE_OP_ADD_WITH_CARRY_OP);
      chkD(24'(res), 24'(x[15:0]));
      chkF(flags_r, x[20:16]);
      chkC(cyc, 2'h1);
    end
    eF = x[20:16];
    $display("add test done");
  endtask : t_add
  task automatic t_shift();
    {fileValue, srcR, baseR} = {3{16'h8001}};
    exec(CIE_OP_ASR1);
    eF = {eF[FL_DC], 4'h9};
    chkD(24'(res), 24'h00_C000);
    chkF(flags_r, eF);
    {baseR, srcR} = {16'h8000, 16'h000F};
    exec(CIE_OP_ASRN);
    eF = {eF[4], 1'b1, eF[2], 1'b0, eF[0]};
    chkD(24'(res), 24'h00_FFFF);
    chkF(flags_r, eF);
    {byLit, litFive, baseR} = {1'b1, 5'h14, 16'h4000};
    exec(CIE_OP_ASRN);
    eF = {eF[4], 1'b0, eF[2], 1'b0, eF[0]};
    chkD(24'(res), 24'h00_0400);
    chkF(flags_r, eF);
    {fileValue, srcR, baseR} = {3{16'h0001}};
    exec(CIE_OP_ASR1);
    eF = {eF[4], 4'h3};
    chkF(flags_r, eF);
    chkC(cyc, 2'h1);
    $display("shift test done");
  endtask : t_shift
  task automatic t_skip();
    srcR = 16'h0008;
    for (int j = 0; j < 3; j++) begin
      bitSel = (j == 0) ? 4'h3 : 4'h2;
      twoWord = (j == 2);
      exec(CIE_OP_BIT_TEST_SKIP_CLEAR_OP);
      chkC(cyc, 2'(j + 1));
      chkD(24'(skp), 24'(j != 0));
      chkF(flags_r, eF);
    end
    $display("skip test done");
  endtask : t_skip
  task automatic t_table();
    {srcR, dstR, baseR} = {3{16'h0005}};
    exec(CIE_OP_TBLRD_LOW);
    chkC(cyc, 2'h2);
    chkD(24'({rdE, rV, res}), 24'({1'b1, 1'b1, 16'h5FC3}));
    srcR = 16'hABCD;
    exec(CIE_OP_TBLWR_HIGH);
    chkC(cyc, 2'h2);
    chkD(wD & wM, 24'hCD_0000);
    chkD(wM, 24'hFF_0000);
    exec(CIE_OP_TBLWR_LOW);
    chkC(cyc, 2'h2);
    chkD(wD & wM, 24'h00_ABCD);
    chkD(24'({wrE, wM[23]}), 24'h00_0002);
    chkF(flags_r, eF);
    // Read the word back so the write address and low lane are proven too
    srcR = 16'h0005;
    exec(CIE_OP_TBLRD_LOW);
    chkD(24'(res), 24'h00_ABCD);
    $display("table test done");
  endtask : t_table
  task automatic t_zext();
    srcR = 16'hFF80;
    exec(CIE_OP_ZEXT);
    eF = {eF[4], 1'b0, eF[2], 2'h1};
    chkD(24'(res), 24'h00_0080);
    chkF(flags_r, eF);
    srcR = 16'h1200;
    exec(CIE_OP_ZEXT);
    eF = {eF[4], 1'b0, eF[2], 2'h3};
    chkD(24'(res), 24'h00_0000);
    chkF(flags_r, eF);
    $display("zero extend test done");
  endtask : t_zext
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    chkF(flags_r, FLAGS_RST);
    chkD(24'({busy, result_r}), 24'h00_0000);
    t_branch(16'h3D4A, FLAGS_RST);
    t_add();
    t_shift();
    t_skip();
    t_table();
    t_zext();
    // Carry and zero now set, so C, NC, Z, NZ, GEU, LTU, GT and LE flip their outcome
    t_branch(16'h9867, eF);
    print_verdict();
  end
endmodule : cpu_instruction_subset_exec_tb
bind cie_exec cie_exec_sva chk (.*);
`default_nettype wire
